// *** verilog/fpw_top.v ***
// Flash page buffer, program sequencer and CPU wait control
// Operation
// RULE1 - Flash is 512 pages of 64 bytes at 8000H..FFFFH.
// RULE2 - Writes gather in a 64-byte buffer; full buffer starts programming.
// RULE3 - Each page program erases the page first automatically.
// RULE4 - Program time from own oscillator, about 4 ms per page; here it is counted as PROG_CYC hclk cycles instead.
// RULE5 - Flash control circuit power can be removed when unused.
// RULE6 - Host writes flash only in serial PROM mode.
// RULE7 - A 2 KB boot ROM provides programming in serial PROM mode; here the 2048-byte boot ROM is left blank (all FFH).
// RULE8 - Reset wait halts CPU and peripherals 2^10 fast clocks.
// RULE9 - Stop to normal with stop power-down set waits 2^10 fast.
// RULE10 - Stop to slow with stop power-down set waits 2^3 slow.
// RULE11 - Idle to normal with idle power-down clear waits 2^10 fast.
// RULE12 - Sleep to slow with idle power-down clear waits 2^3 slow.
// RULE13 - Interrupts latch during wait; service starts after wait ends.
// RULE14 - While busy, flash reads return FFH; fetching it raises swi.
// RULE15 - NMI during write sets flag, aborts, clears count, then waits.
// RULE16 - Reading the status register clears the interrupted flag.
// RULE17 - Writes allowed only with protect code 0011B; reset loads 1100B.
// RULE18 - Busy from first buffered byte until program completes.
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "fpw_map.vh"
module fpw_top #(
  parameter PROG_CYC = `FPW_PROG_CYC
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        slow_tick,
  input  wire        wake_stop,
  input  wire        wake_idle,
  input  wire        slow_mode,
  input  wire        nmi_in,
  input  wire        irq_in,
  input  wire        interrupt_master_flag,
  output reg         cpu_halt,
  output reg         periph_halt,
  output reg         irq_latch,
  output reg         irq_take,
  output reg         swi_out,
  output reg         flash_pwr_en,
  output reg         flash_prog,
  output reg         flash_erase,
  output reg  [8:0]  flash_page,
  output reg  [7:0]  flash_wdata,
  output reg  [5:0]  flash_widx
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_ERASE = 2'd1;
  localparam ST_PROG  = 2'd2;

  reg [7:0]  flash_control_reg;
  reg        write_interrupted_flag;
  reg        busy_reg;
  reg [6:0]  count_reg;
  reg [8:0]  page_reg;
  reg [1:0]  state_reg;
  reg [22:0] timer_reg;
  reg [7:0]  page_buf [0:63];
  reg [7:0]  flash_mem [0:32767];
  reg [7:0]  boot_rom [0:2047];
  reg [7:0]  rd_byte;
  reg        ap_valid;
  reg        ap_write;
  reg [7:0]  ap_addr;
  reg [1:0]  nmi_sync;
  reg [1:0]  irq_sync;
  reg [1:0]  stop_sync;
  reg [1:0]  idle_sync;
  reg        nmi_prev;
  reg        rst_wait_reg;
  reg        wait_start;
  reg        wait_slow;
  reg [6:0]  erase_idx;
  wire       wait_busy;
  wire       wr_data;
  wire       nmi_edge;
  integer    i;

  // Flash byte index from a CPU address in 8000H..FFFFH
  function [14:0] flash_index;
    input [15:0] a;
    begin
      flash_index = a[14:0];
    end
  endfunction

  // Byte write reaches the buffer only when allowed
  // RULE17 protect code gate
  assign wr_data = ap_valid && ap_write && (ap_addr == `FPW_DATA_OFS) &&
                   (flash_control_reg[`FPW_CTRL_WP_MSB:`FPW_CTRL_WP_LSB] == `FPW_WP_ENABLE) &&
                   flash_control_reg[`FPW_CTRL_SERPROM] && flash_control_reg[`FPW_CTRL_FPWR] &&
                   !wait_busy && (state_reg == ST_IDLE) && (count_reg != 7'd64);
  assign nmi_edge = nmi_sync[1] && !nmi_prev;

  // Pin inputs through two flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_sync  <= 2'b00;
      irq_sync  <= 2'b00;
      stop_sync <= 2'b00;
      idle_sync <= 2'b00;
      nmi_prev  <= 1'b0;
    end else begin
      nmi_sync  <= {nmi_sync[0], nmi_in};
      irq_sync  <= {irq_sync[0], irq_in};
      stop_sync <= {stop_sync[0], wake_stop};
      idle_sync <= {idle_sync[0], wake_idle};
      nmi_prev  <= nmi_sync[1];
    end
  end

  // Wait start selection per wake source
  always @* begin
    wait_start = 1'b0;
    wait_slow  = slow_mode;
    if (rst_wait_reg) begin
      wait_start = 1'b1;
      wait_slow  = 1'b0;
    // RULE9 RULE10 stop wake
    end else if (stop_sync[1] && flash_control_reg[`FPW_CTRL_STOPPD]) begin
      wait_start = 1'b1;
    // RULE11 RULE12 idle wake
    end else if (idle_sync[1] && !flash_control_reg[`FPW_CTRL_IDLEPD]) begin
      wait_start = 1'b1;
    // RULE15 warm-up after abort
    end else if (nmi_edge && busy_reg) begin
      wait_start = 1'b1;
    end
  end

  fpw_wait_timer u_wait (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .start     (wait_start),
    .slow_sel  (wait_slow),
    .slow_tick (slow_tick),
    .busy      (wait_busy)
  );

  // Halt outputs and interrupt latch
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_wait_reg <= 1'b1;
      cpu_halt     <= 1'b1;
      periph_halt  <= 1'b1;
      irq_latch    <= 1'b0;
      irq_take     <= 1'b0;
      flash_pwr_en <= 1'b0;
    end else begin
      rst_wait_reg <= 1'b0;
      // RULE8 reset halts all
      cpu_halt     <= wait_busy || wait_start;
      periph_halt  <= (wait_busy || wait_start) && periph_halt;
      // RULE5 power gating
      flash_pwr_en <= flash_control_reg[`FPW_CTRL_FPWR];
      // RULE13 latch, defer service
      if (irq_sync[1])
        irq_latch <= 1'b1;
      else if (irq_take)
        irq_latch <= 1'b0;
      irq_take <= irq_latch && interrupt_master_flag && !wait_busy && !cpu_halt && !irq_take;
    end
  end

  // Bus address phase capture; zero-wait slave
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end else begin
      ap_valid <= 1'b0;
    end
  end

  // Read data mux registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `FPW_CTRL_OFS:  hrdata <= {24'h000000, flash_control_reg};
        `FPW_STAT_OFS:  hrdata <= {28'h0000000, wait_busy, flash_pwr_en && !wait_busy,
                                   write_interrupted_flag, busy_reg};
        `FPW_MODE_OFS:  hrdata <= {25'h0000000, count_reg};
        `FPW_FREAD_OFS: hrdata <= {24'h000000, rd_byte};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Flash and boot read from the address phase byte address
  // RULE14 busy returns FFH
  always @* begin
    rd_byte = `FPW_ERASED;
    if (!busy_reg && hwdata[15])
      rd_byte = flash_mem[flash_index(hwdata[15:0])];
    else if (!busy_reg)
      rd_byte = boot_rom[hwdata[10:0]];
  end

  // Control register and interrupted flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // RULE17 reset protects
      flash_control_reg      <= `FPW_CTRL_RESET;
      write_interrupted_flag <= 1'b0;
      swi_out                <= 1'b0;
    end else begin
      if (ap_valid && ap_write && ap_addr == `FPW_CTRL_OFS)
        flash_control_reg <= hwdata[7:0];
      // RULE15 set wins; RULE16 read clears
      if (nmi_edge && busy_reg)
        write_interrupted_flag <= 1'b1;
      else if (ap_valid && !ap_write && ap_addr == `FPW_STAT_OFS)
        write_interrupted_flag <= 1'b0;
      // RULE14 fetch of FFH traps
      swi_out <= ap_valid && !ap_write && ap_addr == `FPW_FREAD_OFS && busy_reg;
    end
  end

  // Page buffer fill and program sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg    <= 1'b0;
      count_reg   <= 7'd0;
      page_reg    <= 9'd0;
      state_reg   <= ST_IDLE;
      timer_reg   <= 23'd0;
      erase_idx   <= 7'd0;
      flash_prog  <= 1'b0;
      flash_erase <= 1'b0;
      flash_page  <= 9'd0;
      flash_wdata <= 8'h00;
      flash_widx  <= 6'd0;
    end else if (nmi_edge && busy_reg) begin
      // RULE15 abort, count cleared
      busy_reg    <= 1'b0;
      count_reg   <= 7'd0;
      state_reg   <= ST_IDLE;
      flash_prog  <= 1'b0;
      flash_erase <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // RULE2 RULE18 fill buffer
          if (wr_data) begin
            page_buf[count_reg[5:0]] <= hwdata[7:0];
            // RULE1 page from address
            page_reg  <= hwdata[29:21];
            busy_reg  <= 1'b1;
            count_reg <= count_reg + 7'd1;
          end else if (count_reg == 7'd64) begin
            state_reg   <= ST_ERASE;
            flash_erase <= 1'b1;
            flash_page  <= page_reg;
            erase_idx   <= 7'd0;
          end
        end
        // RULE3 automatic erase
        ST_ERASE: begin
          flash_mem[{page_reg, erase_idx[5:0]}] <= `FPW_ERASED;
          erase_idx <= erase_idx + 7'd1;
          if (erase_idx == 7'd63) begin
            state_reg   <= ST_PROG;
            flash_erase <= 1'b0;
            flash_prog  <= 1'b1;
            timer_reg   <= PROG_CYC[22:0];
            erase_idx   <= 7'd0;
          end
        end
        // RULE4 timed program
        ST_PROG: begin
          if (erase_idx != 7'd64) begin
            flash_mem[{page_reg, erase_idx[5:0]}] <= page_buf[erase_idx[5:0]];
            flash_wdata <= page_buf[erase_idx[5:0]];
            flash_widx  <= erase_idx[5:0];
            erase_idx   <= erase_idx + 7'd1;
          end
          // Saturating, so a short program time still copies all bytes
          if (timer_reg != 23'd0)
            timer_reg <= timer_reg - 23'd1;
          if ((timer_reg <= 23'd1) && (erase_idx == 7'd64)) begin
            // RULE18 done clears busy
            state_reg  <= ST_IDLE;
            busy_reg   <= 1'b0;
            count_reg  <= 7'd0;
            flash_prog <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // RULE7 boot ROM contents left blank here
  initial begin
    for (i = 0; i < `FPW_BOOT_BYTES; i = i + 1)
      boot_rom[i] = `FPW_ERASED;
  end
endmodule
`default_nettype wire

// *** pkg/fpw_map.vh ***
// Register offsets, fields, reset values and timing counts of the flash page writer
`ifndef FPW_MAP_VH
`define FPW_MAP_VH
// Register byte offsets on the AHB-Lite port
`define FPW_CTRL_OFS       8'h00
`define FPW_STAT_OFS       8'h04
`define FPW_DATA_OFS       8'h08
`define FPW_MODE_OFS       8'h0C
`define FPW_FREAD_OFS      8'h10
// Control register fields
`define FPW_CTRL_WP_LSB    0
`define FPW_CTRL_WP_MSB    3
`define FPW_CTRL_STOPPD    4
`define FPW_CTRL_IDLEPD    5
`define FPW_CTRL_FPWR      6
`define FPW_CTRL_SERPROM   7
`define FPW_CTRL_RESET     8'h0C
`define FPW_WP_ENABLE      4'h3
`define FPW_WP_DISABLE     4'hC
// Status register fields
`define FPW_STAT_BUSY      0
`define FPW_STAT_WRITE_INTERRUPTED_FLAG      1
`define FPW_STAT_READY     2
`define FPW_STAT_WAIT      3
// Flash geometry
`define FPW_FLASH_BASE     16'h8000
`define FPW_PAGE_BYTES     64
`define FPW_PAGES          512
`define FPW_BOOT_BASE      16'h3800
`define FPW_BOOT_BYTES     2048
`define FPW_ERASED         8'hFF
// Timing: program time in ns, clocks at 50 MHz (20 ns)
`define FPW_CLK_NS         20
`define FPW_PROG_NS        4000000
`define FPW_PROG_CYC       (`FPW_PROG_NS / `FPW_CLK_NS)
`define FPW_FAST_WAIT      1024
`define FPW_SLOW_WAIT      8
`endif

// *** verilog/fpw_wait_timer.v ***
// CPU wait timer counting fast clocks or slow clock enables
`timescale 1ns/10ps
`default_nettype none
`include "fpw_map.vh"
module fpw_wait_timer (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        start,
  input  wire        slow_sel,
  input  wire        slow_tick,
  output reg         busy
);
  reg [10:0] cnt_reg;
  reg        slow_reg;

  // Load on start, count down on the selected rate
  // Rate latched at start so a mode change mid-wait cannot stretch it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg  <= 11'h000;
      slow_reg <= 1'b0;
      busy     <= 1'b0;
    end else if (start) begin
      cnt_reg  <= slow_sel ? 11'd`FPW_SLOW_WAIT : 11'd`FPW_FAST_WAIT;
      slow_reg <= slow_sel;
      busy     <= 1'b1;
    end else if (busy && (!slow_reg || slow_tick)) begin
      cnt_reg <= cnt_reg - 11'h001;
      busy    <= (cnt_reg != 11'h001);
    end
  end
endmodule
`default_nettype wire

// *** tb/fpw_monitor.sv ***
// Concurrent checks on the flash page writer ports
`timescale 1ns/10ps
`default_nettype none
module fpw_monitor #(
  parameter PROG_CYC = 50
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       slow_mode,
  input wire logic       slow_tick,
  input wire logic       irq_in,
  input wire logic       interrupt_master_flag,
  input wire logic       cpu_halt,
  input wire logic       periph_halt,
  input wire logic       irq_latch,
  input wire logic       irq_take,
  input wire logic       flash_pwr_en,
  input wire logic       flash_prog,
  input wire logic       flash_erase,
  input wire logic [8:0] flash_page
);
  logic [11:0] halt_cnt;
  logic [3:0]  tick_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Length of the current halt, in clocks and in slow ticks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halt_cnt <= 12'h000;
      tick_cnt <= 4'h0;
    end else if (!cpu_halt) begin
      halt_cnt <= 12'h000;
      tick_cnt <= 4'h0;
    end else begin
      halt_cnt <= halt_cnt + 12'h001;
      tick_cnt <= tick_cnt + {3'h0, slow_tick};
    end
  end
  a_periph_with_cpu: assert property (periph_halt |-> cpu_halt) else $error("periph halt alone");
  a_periph_no_rise: assert property (!$past(periph_halt) |-> !periph_halt) else $error("periph halt rose");
  a_fast_wait_len: assert property ($fell(cpu_halt) && !slow_mode |->
    halt_cnt >= 12'h3FF && halt_cnt <= 12'h403) else $error("fast wait length");
  a_slow_wait_len: assert property ($fell(cpu_halt) && slow_mode |->
    tick_cnt >= 4'h8 && tick_cnt <= 4'h9) else $error("slow wait length");
  a_take_unhalted: assert property (irq_take |-> $past(irq_latch) && !$past(cpu_halt)) else $error("take in wait");
  a_take_pulse: assert property (irq_take |=> !irq_take) else $error("take too long");
  a_latch_seen: assert property ($rose(irq_in) |-> ##[1:5] irq_latch) else $error("irq not latched");
  a_erase_first: assert property ($rose(flash_prog) |-> $past(flash_erase)) else $error("prog without erase");
  a_prog_power: assert property (flash_prog || flash_erase |-> flash_pwr_en) else $error("prog unpowered");
  a_page_steady: assert property (flash_prog && $past(flash_prog) |-> $stable(flash_page)) else $error("page moved");
  c_prog: cover property ($rose(flash_prog));
  c_take: cover property (irq_take);
  c_slow: cover property ($fell(cpu_halt) && slow_mode);
endmodule
bind fpw_top fpw_monitor #(.PROG_CYC(PROG_CYC)) u_mon (
  .hclk                  (hclk),
  .hresetn               (hresetn),
  .slow_mode             (slow_mode),
  .slow_tick             (slow_tick),
  .irq_in                (irq_in),
  .interrupt_master_flag (interrupt_master_flag),
  .cpu_halt              (cpu_halt),
  .periph_halt           (periph_halt),
  .irq_latch             (irq_latch),
  .irq_take              (irq_take),
  .flash_pwr_en          (flash_pwr_en),
  .flash_prog            (flash_prog),
  .flash_erase           (flash_erase),
  .flash_page            (flash_page)
);
`default_nettype wire

// *** tb/fpw_cpu_model.sv ***
// CPU side model: AHB-Lite single transfers and the slow clock tick
`timescale 1ns/10ps
`default_nettype none
module fpw_cpu_model (
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  output var  logic        slow_tick
);
  logic [3:0] tick_div = 4'h0;
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // Low clock as an enable every 16 fast clocks
  always @(posedge hclk) begin
    tick_div <= tick_div + 4'h1;
    slow_tick <= (tick_div == 4'hF);
  end
  // One word transfer; each phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~d; // Reads leave no stale data
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    r = hrdata;
  endtask
endmodule
`default_nettype wire

// *** tb/flash_page_write_and_cpu_wait_tb.sv ***
// Self-checking bench for the flash page writer and CPU wait
`timescale 1ns/10ps
`default_nettype none
`include "fpw_map.vh"
module flash_page_write_and_cpu_wait_tb;
  typedef struct {string n; logic [31:0] m; logic [31:0] v;} fpw_note_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, slow_tick, rd_ph = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        wake_stop, wake_idle, slow_mode, nmi_in, irq_in, interrupt_master_flag;
  logic        cpu_halt, periph_halt, irq_latch, irq_take, swi_out, flash_pwr_en, flash_prog, flash_erase;
  logic [8:0]  flash_page;
  logic [7:0]  flash_wdata;
  logic [5:0]  flash_widx;
  fpw_note_t   notes[$];
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          swi_n = 0;
  localparam int PROG = 100;
  fpw_top #(.PROG_CYC(PROG)) DUT (.hready(hreadyout), .*);
  fpw_cpu_model cpu (.*);
  always #10 hclk = ~hclk;
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    cpu.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input string n, input logic [31:0] m,
                    input logic [31:0] v, output logic [31:0] r);
    notes.push_back('{n, m, v});
    cpu.xfer(1'b0, a, d, r);
  endtask
  // Read results meet the oldest note; also the hang limit
  always @(posedge hclk) begin
    if (rd_ph && hreadyout && notes.size() > 0) begin
      cmp(notes[0].n, notes[0].v & notes[0].m, hrdata & notes[0].m);
      cmp("hresp", 32'h0, {31'h0, hresp});
      void'(notes.pop_front());
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
    swi_n <= swi_n + (swi_out ? 1 : 0);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    logic [31:0] r;
    logic [8:0]  pg;
    logic [7:0]  pb [0:63];
    int          k, n, t;
    {wake_stop, wake_idle, slow_mode, nmi_in, irq_in, interrupt_master_flag} = '0;
    void'($urandom(32'h1185e423));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (n = 0; n < 1100 && cpu_halt; n++) @(posedge hclk);
    cmp("reset wait", 1, n >= 1020 && n <= 1028);
    rd(`FPW_CTRL_OFS, 0, "ctrl reset", 32'hFF, 32'h0C, r);
    rd(8'h14, 0, "unmapped", 32'hFFFFFFFF, 0, r);
    wr(`FPW_DATA_OFS, 32'h5A);
    rd(`FPW_MODE_OFS, 0, "locked count", 32'h7F, 0, r);
    // Protect open and PROM mode set before any flash write
    wr(`FPW_CTRL_OFS, 32'hC3);
    for (k = 0; k < 2000 && !r[2]; k++) rd(`FPW_STAT_OFS, 0, "poll", 0, 0, r);
    cmp("ready", 1, r[2]);
    // Full page: busy, blanked reads, erase then program
    pg = 9'($urandom);
    for (k = 0; k < 64; k++) pb[k] = 8'($urandom);
    wr(`FPW_DATA_OFS, {2'h0, pg, 13'h0, pb[0]});
    rd(`FPW_STAT_OFS, 0, "busy set", 32'h1, 32'h1, r);
    rd(`FPW_MODE_OFS, 0, "count one", 32'h7F, 32'h1, r);
    t = swi_n;
    rd(`FPW_FREAD_OFS, 32'h8000, "busy read", 32'hFF, 32'hFF, r);
    repeat (3) @(posedge hclk);
    cmp("swi", t + 1, swi_n);
    for (k = 1; k < 64; k++) wr(`FPW_DATA_OFS, {2'h0, pg, 13'h0, pb[k]});
    for (k = 0; k < 100 && !flash_erase; k++) @(posedge hclk);
    cmp("erase", 1, flash_erase);
    cmp("page", {23'h0, pg}, {23'h0, flash_page});
    for (k = 0; k < 200 && !flash_prog; k++) @(posedge hclk);
    for (k = 0; k < 200 && flash_prog; k++) @(posedge hclk);
    cmp("prog time", 1, k >= PROG - 1 && k <= PROG + 2);
    cmp("widx", 32'd63, {26'h0, flash_widx});
    cmp("wdata", {24'h0, pb[63]}, {24'h0, flash_wdata});
    rd(`FPW_STAT_OFS, 0, "busy clear", 32'h1, 0, r);
    rd(`FPW_MODE_OFS, 0, "count clear", 32'h7F, 0, r);
    // Programmed bytes read back, last byte of the page included
    for (k = 0; k < 64; k += 9) rd(`FPW_FREAD_OFS, {16'h0, 1'b1, pg, 6'(k)}, "flash byte", 32'hFF, {24'h0, pb[k]}, r);
    // Abort by nmi in mid-page
    for (k = 0; k < 5; k++) wr(`FPW_DATA_OFS, 32'($urandom) & 32'h3FE000FF);
    nmi_in <= 1'b1;
    repeat (4) @(posedge hclk);
    nmi_in <= 1'b0;
    repeat (4) @(posedge hclk);
    cmp("nmi wait", 1, cpu_halt);
    rd(`FPW_STAT_OFS, 0, "write_interrupted_flag set", 32'h2, 32'h2, r);
    rd(`FPW_STAT_OFS, 0, "write_interrupted_flag clear", 32'h2, 0, r);
    rd(`FPW_MODE_OFS, 0, "abort count", 32'h7F, 0, r);
    for (k = 0; k < 1200 && cpu_halt; k++) @(posedge hclk);
    cmp("nmi wait end", 0, cpu_halt);
    // Wake table: stop/idle x normal/slow, then pd bits that skip the wait
    interrupt_master_flag <= 1'b1;
    for (n = 0; n < 6; n++) begin
      wr(`FPW_CTRL_OFS, n < 4 ? 32'hD3 : 32'hE3);
      slow_mode <= n[1];
      if (n[0]) wake_idle <= 1'b1;
      else wake_stop <= 1'b1;
      @(posedge hclk);
      {wake_idle, wake_stop} <= 2'h0;
      repeat (6) @(posedge hclk);
      cmp("wake wait", n < 4, cpu_halt);
      cmp("periph run", 0, periph_halt);
      irq_in <= (n == 0);
      repeat (6) @(posedge hclk);
      irq_in <= 1'b0;
      if (n == 0) cmp("latch", 1, irq_latch);
      for (k = 0; k < 1200 && cpu_halt; k++) @(posedge hclk);
      cmp("wait end", 0, cpu_halt);
      for (t = 0; n == 0 && t < 8 && !irq_take; t++) @(posedge hclk);
      if (n == 0) cmp("take", 1, irq_take);
    end
    final_report();
  end
endmodule
`default_nettype wire
